// file: isc_pkg.sv
// Function
// - private cfg bits 31:30 hold ID 31 (legacy irq input), reset 0x1 low-level.
// - private cfg bits 29:28 hold ID 30 watchdog, reset 0x3 edge-sensitive.
// - private cfg bits 27:26 hold ID 29 private timer, reset 0x3 edge-sensitive.
// - private cfg bits 25:24 hold ID 28 (legacy fast irq input), reset 0x1 low-level.
// - private cfg bits 23:22 hold ID 27 global timer, reset 0x3 edge-sensitive.
// - private cfg bits 21:0 have no effect; writes to them are ignored.
// - shared field value 01 means high-level sensing, 11 means rising-edge sensing.
// - shared field lower bit is read-only one; only the upper bit is writable.
// - every shared field resets to 0x1, high-level sensing.
// - cfg_a holds IDs 47,44,43,42,39,32 at 31:30,25:24,23:22,21:20,15:14,1:0.
// - cfg_b holds IDs 63,59,58,52,48 at 31:30,23:22,21:20,9:8,1:0.
// - cfg_c holds IDs 79,68,64 at 31:30,9:8,1:0.
// - the four registers decode at base 0xF8F00000 plus 0x1C04..0x1C10.
package isc_pkg;

  // address map
  localparam logic [31:0] ISC_DIST_BASE = 32'hF8F0_0000;
  localparam logic [31:0] ISC_OFS_PRIV = 32'h0000_1C04;
  localparam logic [31:0] ISC_OFS_CFG_A = 32'h0000_1C08;
  localparam logic [31:0] ISC_OFS_CFG_B = 32'h0000_1C0C;
  localparam logic [31:0] ISC_OFS_CFG_C = 32'h0000_1C10;

  // register select codes
  localparam logic [2:0] ISC_SEL_NONE = 3'h0;
  localparam logic [2:0] ISC_SEL_PRIV = 3'h1;
  localparam logic [2:0] ISC_SEL_A = 3'h2;
  localparam logic [2:0] ISC_SEL_B = 3'h3;
  localparam logic [2:0] ISC_SEL_C = 3'h4;

  // interrupt ID ranges
  localparam int ISC_ID_FIRST = 27;
  localparam int ISC_ID_LAST = 79;
  localparam int ISC_SPI_FIRST = 32;
  localparam int ISC_FIELDS = 16;
  localparam int ISC_PRIV_FIELD0 = 11;
  localparam int ISC_ID_LEGACY_FIQ = 28;
  localparam int ISC_ID_LEGACY_IRQ = 31;

  // implemented field masks, one bit per 2-bit field
  localparam logic [15:0] ISC_MASK_PRIV = 16'hF800;
  localparam logic [15:0] ISC_MASK_A = 16'h9C81;
  localparam logic [15:0] ISC_MASK_B = 16'h8C11;
  localparam logic [15:0] ISC_MASK_C = 16'h8011;

  // private field reset values, index 0 is ID 27
  localparam logic [1:0] ISC_RST_ID27 = 2'h3;
  localparam logic [1:0] ISC_RST_ID28 = 2'h1;
  localparam logic [1:0] ISC_RST_ID29 = 2'h3;
  localparam logic [1:0] ISC_RST_ID30 = 2'h3;
  localparam logic [1:0] ISC_RST_ID31 = 2'h1;
  localparam logic [9:0] ISC_RST_PRIV = {ISC_RST_ID31, ISC_RST_ID30, ISC_RST_ID29, ISC_RST_ID28, ISC_RST_ID27};
  // shared upper bit reset, field then reads 01
  localparam logic ISC_RST_SPI_HI = 1'b0;
  localparam logic ISC_SPI_LO_BIT = 1'b1;

  // address to register select
  function automatic logic [2:0] isc_addr_sel(input logic [31:0] addr);
    logic [2:0] sel;
    sel = ISC_SEL_NONE;
    if (addr == ISC_DIST_BASE + ISC_OFS_PRIV)
      sel = ISC_SEL_PRIV;
    else if (addr == ISC_DIST_BASE + ISC_OFS_CFG_A)
      sel = ISC_SEL_A;
    else if (addr == ISC_DIST_BASE + ISC_OFS_CFG_B)
      sel = ISC_SEL_B;
    else if (addr == ISC_DIST_BASE + ISC_OFS_CFG_C)
      sel = ISC_SEL_C;
    return sel;
  endfunction

endpackage

// file: isc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for pin-level inputs
module isc_sync #(
  parameter int WIDTH = 1,
  // idle level of each pin, so no false edge or level follows reset
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  import isc_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } isc_sync_s;

  isc_sync_s st_q;
  isc_sync_s st_d;

  // first stage feeds only the second stage
  always_comb
  begin
    st_d.meta = async_i;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q.meta <= RST_VAL;
      st_q.stable <= RST_VAL;
    end
    else
      st_q <= st_d;
  end

  assign sync_o = st_q.stable;

endmodule // isc_sync

// file: isc_sense.sv
`timescale 1ns/1ps
// one interrupt line: level follow or edge-captured pending
module isc_sense #(
  parameter logic ACTIVE_LOW = 1'b0
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic line_i,
  input wire logic edge_mode_i,
  input wire logic pend_clr_i,
  output logic req_o
);
  import isc_pkg::*;

  typedef struct packed {
    logic prev;
    logic req;
  } isc_sense_s;

  isc_sense_s st_q;
  isc_sense_s st_d;
  logic active;
  logic rise;

  // active-low legacy lines are turned around here so edges mean assertion
  assign active = line_i ^ ACTIVE_LOW;
  assign rise = active & ~st_q.prev;

  // set beats clear so an edge landing on the clear cycle is kept
  always_comb
  begin
    st_d.prev = active;
    if (edge_mode_i)
      st_d.req = rise | (st_q.req & ~pend_clr_i);
    else
      st_d.req = active;
  end

  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign req_o = st_q.req;

endmodule // isc_sense

// file: isc_sense_cfg.sv
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
// interrupt sensitivity configuration registers with per-line sensing
module isc_sense_cfg (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // register port
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // interrupt lines from pins, index is the interrupt ID
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] irq_line_i,
  // pending clear from the distributor, same clock
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] pend_clr_i,
  // per-ID edge select and request towards the distributor
  output logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] sense_edge_o,
  output logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] irq_req_o
);
  import isc_pkg::*;

  localparam int NSPI = ISC_ID_LAST - ISC_SPI_FIRST + 1;
  localparam int NPRIV = ISC_SPI_FIRST - ISC_ID_FIRST;
  localparam int NLINES = ISC_ID_LAST - ISC_ID_FIRST + 1;
  // legacy lines idle high; their sync flops reset high so they start inactive
  localparam logic [NLINES-1:0] LOW_LINES = (NLINES'(1) << (ISC_ID_LEGACY_FIQ - ISC_ID_FIRST))
    | (NLINES'(1) << (ISC_ID_LEGACY_IRQ - ISC_ID_FIRST));

  typedef struct packed {
    logic [NPRIV-1:0][1:0] priv;
    logic [NSPI-1:0] spi_hi;
    logic [31:0] rdata;
  } isc_cfg_s;

  isc_cfg_s st_q;
  isc_cfg_s st_d;

  logic [2:0] wr_sel;
  logic [2:0] rd_sel;
  logic [31:0] word_priv;
  logic [31:0] word_a;
  logic [31:0] word_b;
  logic [31:0] word_c;
  logic [1:0] wr_idx;
  logic [15:0] wr_mask;
  logic [ISC_ID_LAST:ISC_ID_FIRST] line_sync;

  // shared register index: 0 is cfg_a, 1 cfg_b, 2 cfg_c
  function automatic logic [15:0] spi_mask(input int reg_idx);
    logic [15:0] m;
    m = '0;
    case (reg_idx)
      0: m = ISC_MASK_A;
      1: m = ISC_MASK_B;
      2: m = ISC_MASK_C;
      default: m = '0;
    endcase
    return m;
  endfunction

  // build one shared read word; absent fields read 00
  function automatic logic [31:0] spi_word(input logic [NSPI-1:0] hi, input int reg_idx);
    logic [31:0] w;
    logic [15:0] m;
    w = '0;
    m = spi_mask(reg_idx);
    for (int f = 0; f < ISC_FIELDS; f++)
    begin
      if (m[f])
      begin
        w[2*f+1] = hi[reg_idx*ISC_FIELDS+f];
        w[2*f] = ISC_SPI_LO_BIT;
      end
      // unlisted fields stay zero
    end
    return w;
  endfunction

  // decode both strobes against the distributor map
  assign wr_sel = isc_addr_sel(reg_addr_i);
  assign rd_sel = wr_sel;

  // shared register index and its field mask; only used when a shared register is hit
  assign wr_idx = 2'(wr_sel - ISC_SEL_A);
  assign wr_mask = spi_mask(int'(wr_idx));

  // private word: fields 11..15 hold IDs 27..31, low bits read zero
  always_comb
  begin
    word_priv = '0;
    for (int f = ISC_PRIV_FIELD0; f < ISC_FIELDS; f++)
    begin
      if (ISC_MASK_PRIV[f])
        word_priv[2*f +: 2] = st_q.priv[f-ISC_PRIV_FIELD0];
    end
  end

  assign word_a = spi_word(st_q.spi_hi, 0);
  assign word_b = spi_word(st_q.spi_hi, 1);
  assign word_c = spi_word(st_q.spi_hi, 2);

  // register writes and the one-cycle read answer
  always_comb
  begin
    st_d = st_q;
    st_d.rdata = '0;
    if (reg_wr_i)
    begin
      case (wr_sel)
        ISC_SEL_PRIV:
        begin
          // both bits of each private field are writable; bits 21:0 dropped
          for (int f = ISC_PRIV_FIELD0; f < ISC_FIELDS; f++)
          begin
            if (ISC_MASK_PRIV[f])
              st_d.priv[f-ISC_PRIV_FIELD0] = reg_wdata_i[2*f +: 2];
          end
        end
        ISC_SEL_A, ISC_SEL_B, ISC_SEL_C:
        begin
          // only the upper bit lands; lower bit is fixed at one
          for (int f = 0; f < ISC_FIELDS; f++)
          begin
            if (wr_mask[f])
              st_d.spi_hi[int'(wr_idx)*ISC_FIELDS+f] = reg_wdata_i[2*f+1];
          end
        end
        default:
        begin
          // unmapped write is dropped
        end
      endcase
    end
    if (reg_rd_i)
    begin
      case (rd_sel)
        ISC_SEL_PRIV: st_d.rdata = word_priv;
        ISC_SEL_A: st_d.rdata = word_a;
        ISC_SEL_B: st_d.rdata = word_b;
        ISC_SEL_C: st_d.rdata = word_c;
        default: st_d.rdata = '0; // unmapped reads give zero
      endcase
    end
  end

  // reset: private fields per line, shared fields to high-level
  always_ff @(posedge core_clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_q.priv <= ISC_RST_PRIV;
      st_q.spi_hi <= {NSPI{ISC_RST_SPI_HI}};
      st_q.rdata <= '0;
    end
    else
      st_q <= st_d;
  end

  // data stands only in the cycle after the read strobe
  assign reg_rdata_o = st_q.rdata;

  // pins come from outside the clock domain
  isc_sync #(
    .WIDTH(NLINES),
    .RST_VAL(LOW_LINES)
  ) u_line_sync (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .async_i(irq_line_i),
    .sync_o(line_sync)
  );

  // edge select per ID: upper field bit; private 01 is level, 11 edge
  always_comb
  begin
    sense_edge_o = '0;
    for (int id = ISC_ID_FIRST; id < ISC_SPI_FIRST; id++)
      sense_edge_o[id] = st_q.priv[id-ISC_ID_FIRST][1];
    for (int id = ISC_SPI_FIRST; id <= ISC_ID_LAST; id++)
      sense_edge_o[id] = st_q.spi_hi[id-ISC_SPI_FIRST];
  end

  // one detector per line; the two legacy inputs are low-active
  generate
    for (genvar id = ISC_ID_FIRST; id <= ISC_ID_LAST; id++)
    begin : g_line
      isc_sense #(
        .ACTIVE_LOW((id == ISC_ID_LEGACY_FIQ) || (id == ISC_ID_LEGACY_IRQ))
      ) u_sense (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .line_i(line_sync[id]),
        .edge_mode_i(sense_edge_o[id]),
        .pend_clr_i(pend_clr_i[id]),
        .req_o(irq_req_o[id])
      );
    end
  endgenerate

endmodule // isc_sense_cfg

// file: isc_sense_cfg_props.sv
`timescale 1ns/1ps
// watches the register port and the per-line outputs
module isc_sense_cfg_chk (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] irq_line_i,
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] pend_clr_i,
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] sense_edge_o,
  input wire logic [isc_pkg::ISC_ID_LAST:isc_pkg::ISC_ID_FIRST] irq_req_o
);
  import isc_pkg::*;
  localparam logic [31:0] AD_P = ISC_DIST_BASE + ISC_OFS_PRIV;
  localparam logic [31:0] AD_A = ISC_DIST_BASE + ISC_OFS_CFG_A;
  // address hits one of the four registers
  wire logic mapped = reg_addr_i inside {AD_P, AD_A, ISC_DIST_BASE + ISC_OFS_CFG_B, ISC_DIST_BASE + ISC_OFS_CFG_C};
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  // four samples cover both sync flops and the detector
  sequence s_lvl_hi;
    (!sense_edge_o[32] && irq_line_i[32])[*4];
  endsequence
  sequence s_lvl_lo;
    (!sense_edge_o[32] && !irq_line_i[32])[*4];
  endsequence
  // pin quiet long enough that no new edge is in the pipe
  sequence s_quiet39;
    (sense_edge_o[39] && !irq_line_i[39])[*3];
  endsequence
  a_unmapped_read: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 32'h0000_0000)
    else $error("unmapped read returned data");
  a_cfga_fixed: assert property (reg_rd_i && reg_addr_i == AD_A |=> (reg_rdata_o & 32'h4150_4001) == 32'h4150_4001
    && (reg_rdata_o & 32'h3C0F_3FFC) == 32'h0000_0000)
    else $error("fixed bits of shared register wrong");
  a_priv_unused: assert property (reg_rd_i && reg_addr_i == AD_P |=> reg_rdata_o[21:0] == 22'h00_0000)
    else $error("unused private bits read nonzero");
  a_write_edge: assert property (reg_wr_i && reg_addr_i == AD_A |=> sense_edge_o[39] == $past(reg_wdata_i[15]))
    else $error("edge select of line 39 not taken from write");
  a_priv_edge: assert property (reg_wr_i && reg_addr_i == AD_P |=> sense_edge_o[30] == $past(reg_wdata_i[29]))
    else $error("edge select of line 30 not taken from write");
  a_absent_field: assert property (!sense_edge_o[40])
    else $error("absent field selects edge");
  a_level_high: assert property (s_lvl_hi |-> irq_req_o[32])
    else $error("level line not requesting");
  a_level_low: assert property (s_lvl_lo |-> !irq_req_o[32])
    else $error("inactive level line requesting");
  a_edge_sticky: assert property (sense_edge_o[39] && irq_req_o[39] && !pend_clr_i[39] && !reg_wr_i
    |=> irq_req_o[39])
    else $error("edge pending lost without clear");
  a_clear_drops: assert property (s_quiet39 ##0 (pend_clr_i[39] && !reg_wr_i) |=> !irq_req_o[39])
    else $error("edge pending not cleared");
  // sync flops must come out of reset at the idle pin level
  a_legacy_quiet: assert property ($rose(nrst_i) |-> (!irq_req_o[28] && !irq_req_o[31])[*3])
    else $error("legacy line requests right after reset");
endmodule // isc_sense_cfg_chk

bind isc_sense_cfg isc_sense_cfg_chk chk_u (.core_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .reg_rd_i, .reg_rdata_o, .irq_line_i, .pend_clr_i, .sense_edge_o, .irq_req_o);

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import isc_pkg::*;
  localparam logic [31:0] ADR [4] = '{ISC_DIST_BASE + ISC_OFS_PRIV, ISC_DIST_BASE + ISC_OFS_CFG_A,
    ISC_DIST_BASE + ISC_OFS_CFG_B, ISC_DIST_BASE + ISC_OFS_CFG_C};
  // read-back after reset, after all ones, after all zeros
  localparam logic [31:0] RST [4] = '{32'h7DC0_0000, 32'h4150_4001, 32'h4050_0101, 32'h4000_0101};
  localparam logic [31:0] ONES [4] = '{32'hFFC0_0000, 32'hC3F0_C003, 32'hC0F0_0303, 32'hC000_0303};
  localparam logic [31:0] ZERO [4] = '{32'h0000_0000, 32'h4150_4001, 32'h4050_0101, 32'h4000_0101};
  localparam logic [31:0] AD_GAP = ISC_DIST_BASE + 32'h0000_1C14;
  logic core_clk_i;
  logic nrst_i;
  logic [31:0] reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic reg_wr_i;
  logic reg_rd_i;
  logic [31:0] reg_rdata_o;
  logic [ISC_ID_LAST:ISC_ID_FIRST] irq_line_i, pend_clr_i, sense_edge_o, irq_req_o, exp_v;
  int num_errors = 0;
  int comparisons = 0;

  isc_sense_cfg dut_u (.core_clk_i, .nrst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .irq_line_i, .pend_clr_i, .sense_edge_o, .irq_req_o);

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // strobe is dropped at its own edge, so back-to-back calls never double-drive
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    check(reg_rdata_o, exp);
  endtask

  task automatic close_out();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic t_reset();
    for (int i = 0; i < 4; i++)
    begin
      rd(ADR[i], RST[i]);
      check(irq_req_o, 64'h0);
    end
    exp_v = '0;
    exp_v[27] = 1'b1;
    exp_v[29] = 1'b1;
    exp_v[30] = 1'b1;
    check(sense_edge_o, exp_v);
    $display("test reset done");
  endtask

  task automatic t_regs();
    int ids [19] = '{27, 28, 29, 30, 31, 32, 39, 42, 43, 44, 47, 48, 52, 58, 59, 63, 64, 68, 79};
    exp_v = '0;
    foreach (ids[i])
      exp_v[ids[i]] = 1'b1;
    for (int i = 0; i < 4; i++)
      wr(ADR[i], 32'hFFFF_FFFF);
    wr(AD_GAP, 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++)
      rd(ADR[i], ONES[i]);
    rd(AD_GAP, 32'h0000_0000);
    rd(ISC_OFS_CFG_A, 32'h0000_0000);
    check(sense_edge_o, exp_v);
    for (int i = 0; i < 4; i++)
      wr(ADR[i], 32'h0000_0000);
    for (int i = 0; i < 4; i++)
      rd(ADR[i], ZERO[i]);
    check(sense_edge_o, 64'h0);
    $display("test regs done");
  endtask

  // two sync flops plus detector: request shows on the third edge
  task automatic t_level();
    exp_v = '0;
    irq_line_i[32] <= 1'b1;
    irq_line_i[31] <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    exp_v[32] = 1'b1;
    exp_v[31] = 1'b1;
    @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    pend_clr_i[32] <= 1'b1;
    @(posedge core_clk_i);
    pend_clr_i[32] <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    irq_line_i[32] <= 1'b0;
    irq_line_i[31] <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1;
    check(irq_req_o, 64'h0);
    $display("test level done");
  endtask

  task automatic t_edge();
    wr(ADR[1], 32'h0000_8000);
    rd(ADR[1], 32'h4150_C001);
    exp_v = '0;
    exp_v[39] = 1'b1;
    check(sense_edge_o, exp_v);
    irq_line_i[39] <= 1'b1;
    @(posedge core_clk_i);
    irq_line_i[39] <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    repeat (5) @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    pend_clr_i[39] <= 1'b1;
    @(posedge core_clk_i);
    pend_clr_i[39] <= 1'b0;
    #1;
    check(irq_req_o, 64'h0);
    $display("test edge done");
  endtask

  // low-active legacy line in edge mode pends on its falling pin
  task automatic t_legacy();
    wr(ADR[0], 32'h0300_0000);
    exp_v = '0;
    exp_v[28] = 1'b1;
    exp_v[39] = 1'b1;
    check(sense_edge_o, exp_v);
    exp_v[39] = 1'b0;
    irq_line_i[28] <= 1'b0;
    repeat (3) @(posedge core_clk_i);
    irq_line_i[28] <= 1'b1;
    #1;
    check(irq_req_o, exp_v);
    repeat (4) @(posedge core_clk_i);
    #1;
    check(irq_req_o, exp_v);
    pend_clr_i[28] <= 1'b1;
    @(posedge core_clk_i);
    pend_clr_i[28] <= 1'b0;
    #1;
    check(irq_req_o, 64'h0);
    $display("test legacy done");
  endtask

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // whole run is about 55 cycles
  initial
  begin
    #20000;
    num_errors++;
    close_out();
  end

  initial
  begin
    nrst_i = 1'b0;
    reg_addr_i = 32'h0000_0000;
    reg_wdata_i = 32'h0000_0000;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    pend_clr_i = '0;
    irq_line_i = '0;
    irq_line_i[28] = 1'b1;
    irq_line_i[31] = 1'b1;
    repeat (3) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    t_reset();
    t_regs();
    t_level();
    t_edge();
    t_legacy();
    close_out();
  end
endmodule // tb
